// >>> bench/tts_checker.sv
/*
 * Assertions on the bus and timer-0 pin ports of tts_top.
 * Assumes one ref_clk domain, rst synchronous active high, bound by name.
 */
`timescale 1ns/1ps
module tts_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input logic hreadyout,
    input logic [1:0] hresp,
    input logic [31:0] hrdata,
    input logic squareOutPinA,
    input logic squareOutPinAOeN
);
    import tts_pkg::*;
    logic wrA;
    logic rdA;
    assign wrA = hsel && htrans[1] && hready && hwrite;
    assign rdA = hsel && htrans[1] && hready && !hwrite;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_okay;
        hresp == TTS_HRESP_OKAY;
    endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_rd;
        rdA |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd: assert property (p_rd) else $error("read wait wrong");
    property p_wr;
        wrA |=> hreadyout;
    endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_stall;
        $fell(hreadyout) |=> hreadyout;
    endproperty
    a_stall: assert property (p_stall) else $error("stall too long");
    property p_rst;
        $fell(rst) |-> hreadyout && hrdata == TTS_WORD_ZERO && !squareOutPinA && squareOutPinAOeN;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_rdata;
        !$past(rst) && $changed(hrdata) |-> !$past(hreadyout);
    endproperty
    a_rdata: assert property (p_rdata) else $error("hrdata moved");
    property p_force;
        (wrA && haddr == 32'h00000004) |=> ##2 squareOutPinA == $past(hwdata[TTS_CFG_TOG], 2);
    endproperty
    a_force: assert property (p_force) else $error("toggle not forced");
    property p_oe;
        (wrA && haddr == 32'h00000004) |=> ##1 squareOutPinAOeN == !$past(hwdata[TTS_CFG_OE]);
    endproperty
    a_oe: assert property (p_oe) else $error("enable wrong");
    c_rd: cover property (rdA);
    c_tog: cover property ($changed(squareOutPinA));
    c_drive: cover property (!squareOutPinAOeN);
endmodule : tts_checker

bind tts_top tts_checker tts_checker_i (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .squareOutPinA, .squareOutPinAOeN);

// >>> bench/tts_sq_sink.sv
/*
 * Receiver of one square-wave pin: measures half periods on the driven wire.
 * Assumes the pin is sampled on ref_clk.
 */
`timescale 1ns/1ps
module tts_sq_sink (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    input wire logic pinOeN,
    output logic wireLvl,
    output int unsigned edgeCnt,
    output int unsigned highLen,
    output int unsigned lowLen
);
    logic last_q;
    int unsigned run_q;
    // An undriven wire shows the inverse of the last driven level.
    assign wireLvl = pinOeN ? ~last_q : pin;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_q <= 1'b0;
            run_q <= 0;
            edgeCnt <= 0;
            highLen <= 0;
            lowLen <= 0;
        end else if (pinOeN) begin
            run_q <= 0;
        end else if (pin != last_q) begin
            last_q <= pin;
            run_q <= 1;
            edgeCnt <= edgeCnt + 1;
            if (last_q) begin
                highLen <= run_q;
            end else begin
                lowLen <= run_q;
            end
        end else begin
            run_q <= run_q + 1;
        end
    end
endmodule : tts_sq_sink

// >>> bench/tts_top_tb.sv
/*
 * Self-checking bench for tts_top over AHB-Lite.
 * Assumes the slave answers writes with no wait and reads with one wait state.
 */
`timescale 1ns/1ps
module tts_top_tb;
    import tts_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic [1:0] hresp;
    logic [31:0] hrdata;
    logic [2:0] extDiv = 3'h0;
    logic [2:0] pins;
    logic [2:0] oen;
    logic wl [3];
    int unsigned edg [3];
    int unsigned hiLen [3];
    int unsigned loLen [3];
    int miscompares = 0;
    int checks = 0;
    logic [31:0] r;
    logic [31:0] base;
    int unsigned n;
    int unsigned e0;
    logic [1:0] cks [3] = '{2'h0, 2'h1, 2'h2};
    logic [15:0] rl [3] = '{16'hfff0, 16'hfffc, 16'hfffe};
    int unsigned div [3] = '{1, 12, 8};
    logic [4:0] offs [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};

`define CHK(nm, e, g) \
    checks++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) extDiv <= extDiv + 3'h1;
    assign hready = hreadyout;

    tts_top tts_top_i (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .timerExtIn({3{extDiv[2]}}),
        .squareOutPinA(pins[0]), .squareOutPinAOeN(oen[0]), .squareOutPinB(pins[1]),
        .squareOutPinBOeN(oen[1]), .squareOutPinC(pins[2]), .squareOutPinCOeN(oen[2]));

    for (genvar g = 0; g < 3; g++) begin : g_sink
        tts_sq_sink tts_sq_sink_i (.ref_clk, .rst, .pin(pins[g]), .pinOeN(oen[g]), .wireLvl(wl[g]),
            .edgeCnt(edg[g]), .highLen(hiLen[g]), .lowLen(loLen[g]));
    end

    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic wait_rdy(output logic [31:0] d);
        int k;
        k = 0;
        @(negedge ref_clk);
        while (hreadyout !== 1'b1 && k < 20) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 20) begin
            miscompares++;
            summarize();
        end
        d = hrdata;
        @(posedge ref_clk);
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        logic [31:0] x;
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy(x);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(q);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0, r);
        `CHK(nm, e, r)
    endtask : chk_rd

    task automatic wait_edges(input int t, input int unsigned m);
        int unsigned s;
        int k;
        s = edg[t];
        k = 0;
        while (edg[t] < s + m && k < 3000) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 3000) begin
            miscompares++;
            summarize();
        end
    endtask : wait_edges

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        `CHK("pins reset", 6'b111000, {oen, pins})
        for (int t = 0; t < 3; t++) begin
            for (int o = 0; o < 5; o++) begin
                chk_rd({25'h0, 2'(t), offs[o]}, 32'h0, "reset value");
            end
        end
        wr(32'h60, 32'hffffffff);
        chk_rd(32'h60, 32'h0, "unmapped timer");
        chk_rd(32'h14, 32'h0, "unmapped offset");
        $display("test registers done");
        wr(32'h4, 32'h6);
        chk_rd(32'h4, 32'h6, "toggle read high");
        `CHK("forced high", 3'b110, {wl[0], pins[0], oen[0]})
        wr(32'h4, 32'h2);
        chk_rd(32'h4, 32'h2, "toggle read low");
        `CHK("forced low", 2'b00, {pins[0], oen[0]})
        wr(32'h4, 32'h0);
        chk_rd(32'h4, 32'h0, "enable off");
        `CHK("undriven", 1'b1, oen[0])
        $display("test force done");
        for (int t = 0; t < 3; t++) begin
            base = 32'(t) * 32'h20;
            n = (65536 - rl[t]) * div[t];
            chk_rd(base + 32'h10, 32'h0, "count idle");
            e0 = edg[t];
            wr(base + 32'h08, {24'h0, rl[t][7:0]});
            wr(base + 32'h0c, {24'h0, rl[t][15:8]});
            wr(base + 32'h04, {27'h0, cks[t], 3'h3});
            repeat (100) @(posedge ref_clk);
            `CHK("no toggle idle", e0, edg[t])
            wr(base, 32'h4);
            wait_edges(t, 4);
            `CHK("down high half", n, hiLen[t])
            `CHK("down low half", n, loLen[t])
            bus(1'b0, base + 32'h10, 32'h0, r);
            `CHK("down count range", 1'b1, r[15:0] >= rl[t])
            wr(base + 32'h04, {27'h0, cks[t], 3'h2});
            wait_edges(t, 5);
            `CHK("up high half", n, hiLen[t])
            `CHK("up low half", n, loLen[t])
            bus(1'b0, base + 32'h10, 32'h0, r);
            `CHK("up count range", 1'b1, r[15:0] >= rl[t])
            for (int m = 5; m < 7; m++) begin
                wr(base, 32'(m));
                repeat (2) @(posedge ref_clk);
                n = edg[t];
                repeat (200) @(posedge ref_clk);
                `CHK("select no toggle", n, edg[t])
            end
            wr(base, 32'h0);
            $display("test timer %0d done", t);
        end
        summarize();
    end
endmodule : tts_top_tb

// >>> src/tts_pkg.sv
/*
 * Shared constants, register map and types for the three-channel toggle-output timer block.
 * Assumes a single 200 MHz clock domain and an AHB-Lite register bus with 32-bit data.
 */
package tts_pkg;

    localparam int TTS_NUM_TIMERS = 3;
    localparam int TTS_CNT_W = 16;
    localparam logic [15:0] TTS_ALL_ONES = 16'hffff;
    localparam logic [15:0] TTS_CNT_RESET = 16'h0000;

    localparam real TTS_CLK_PERIOD_NS = 5.0;

    // Each timer owns a 32-byte window; the two bits above the window select the timer, and bits 31:7 must be zero.
    localparam int TTS_OFF_W = 5;
    localparam int TTS_SEL_LSB = 5;
    localparam int TTS_SEL_W = 2;
    localparam int TTS_MAP_TOP = 7;
    localparam logic [4:0] TTS_OFF_CTRL = 5'h00;
    localparam logic [4:0] TTS_OFF_CFG = 5'h04;
    localparam logic [4:0] TTS_OFF_RLD_LO = 5'h08;
    localparam logic [4:0] TTS_OFF_RLD_HI = 5'h0c;
    localparam logic [4:0] TTS_OFF_COUNT = 5'h10;

    // Control register fields.
    localparam int TTS_CTRL_W = 3;
    localparam int TTS_CTRL_CAPREL = 0;
    localparam int TTS_CTRL_EXTCNT = 1;
    localparam int TTS_CTRL_RUN = 2;
    localparam logic [2:0] TTS_CTRL_RESET = 3'h0;

    // Configuration register fields.
    localparam int TTS_CFG_DOWN = 0;
    localparam int TTS_CFG_OE = 1;
    localparam int TTS_CFG_TOG = 2;
    localparam int TTS_CFG_CKS_LSB = 3;
    localparam int TTS_CFG_CKS_MSB = 4;
    localparam logic [1:0] TTS_CKS_RESET = 2'h0;

    localparam int TTS_BYTE_W = 8;
    localparam logic [7:0] TTS_BYTE_RESET = 8'h00;
    localparam logic [31:0] TTS_WORD_ZERO = 32'h00000000;

    // Prescaler for the divided reference tick.
    localparam logic [3:0] TTS_PRESCALE_LAST = 4'hb;
    localparam logic [3:0] TTS_PRESCALE_RESET = 4'h0;

    localparam logic [1:0] TTS_HRESP_OKAY = 2'h0;
    localparam int TTS_HTRANS_ACTIVE = 1;

    typedef enum logic [1:0] {
        TTS_CKS_REF = 2'h0,
        TTS_CKS_DIV12 = 2'h1,
        TTS_CKS_PIN = 2'h2
    } tts_cks_t;

    typedef enum logic {
        TTS_BUS_IDLE,
        TTS_BUS_RDWAIT
    } tts_bus_st_t;

endpackage : tts_pkg

// >>> src/tts_tick_gen.sv
/*
 * Count-tick source for one timer: reference clock, reference divided by twelve, or pin edges.
 * Assumes extPin is asynchronous to ref_clk and is synchronised here before any use.
 */
`timescale 1ns/1ps
module tts_tick_gen (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic extPin,
    input tts_pkg::tts_cks_t cks,
    input wire logic extCnt,
    output logic tick
);
    import tts_pkg::*;

    logic pinS1_q;
    logic pinS2_q;
    logic pinS3_q;
    logic [3:0] preCnt_q;
    logic preTick;
    logic pinFall;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinS1_q <= 1'b1;
            pinS2_q <= 1'b1;
            pinS3_q <= 1'b1;
        end else begin
            pinS1_q <= extPin;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || preCnt_q == TTS_PRESCALE_LAST) begin
            preCnt_q <= TTS_PRESCALE_RESET;
        end else begin
            preCnt_q <= preCnt_q + 4'h1;
        end
    end

    assign preTick = (preCnt_q == TTS_PRESCALE_LAST);
    assign pinFall = pinS3_q & ~pinS2_q;

    always_comb begin
        if (extCnt) begin
            tick = pinFall;
        end else begin
            unique case (cks)
                TTS_CKS_REF: tick = 1'b1;
                TTS_CKS_DIV12: tick = preTick;
                TTS_CKS_PIN: tick = pinFall;
                default: tick = 1'b1;
            endcase
        end
    end
endmodule : tts_tick_gen

// >>> src/tts_timer.sv
/*
 * One 16-bit auto-reload timer channel with toggle output.
 * Assumes configuration arrives through the carrier from the register block on the same clock.
 */
`timescale 1ns/1ps
module tts_timer (
    input wire logic ref_clk,
    input wire logic rst,
    tts_timer_if.tmr tif
);
    import tts_pkg::*;

    logic [15:0] count_q;
    logic toggle_q;
    logic atLimit;
    logic wrapEvent;
    logic reloadMode;

    assign atLimit = tif.down ? (count_q == tif.reloadValue) : (count_q == TTS_ALL_ONES);
    assign wrapEvent = tif.run & tif.tick & atLimit;
    assign reloadMode = ~tif.capRel & ~tif.extCnt;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= TTS_CNT_RESET;
        end else if (tif.run && tif.tick) begin
            if (tif.down) begin
                count_q <= atLimit ? TTS_ALL_ONES : count_q - 16'h0001;
            end else begin
                count_q <= atLimit ? tif.reloadValue : count_q + 16'h0001;
            end
        end
    end

    // A forced level takes effect one cycle after the configuration write and wins over a coincident wrap.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            toggle_q <= 1'b0;
        end else if (tif.forceWr) begin
            toggle_q <= tif.forceVal;
        end else if (wrapEvent && reloadMode) begin
            toggle_q <= ~toggle_q;
        end
    end

    assign tif.count = count_q;
    assign tif.toggleState = toggle_q;
endmodule : tts_timer

// >>> src/tts_timer_if.sv
/*
 * Carrier between the register block and one timer channel.
 * Assumes all members are driven on ref_clk; the tick is driven by the tick generator.
 */
`timescale 1ns/1ps
interface tts_timer_if;
    logic run;
    logic capRel;
    logic extCnt;
    logic down;
    logic outEn;
    logic forceWr;
    logic forceVal;
    logic tick;
    logic [15:0] reloadValue;
    logic [15:0] count;
    logic toggleState;

    modport ctl (
        output run,
        output capRel,
        output extCnt,
        output down,
        output outEn,
        output forceWr,
        output forceVal,
        output reloadValue,
        input count,
        input toggleState
    );

    modport tmr (
        input run,
        input capRel,
        input extCnt,
        input down,
        input outEn,
        input forceWr,
        input forceVal,
        input tick,
        input reloadValue,
        output count,
        output toggleState
    );
endinterface : tts_timer_if

// >>> src/tts_top.sv
/*
 * Three toggle-output timers with an AHB-Lite register slave.
 * Assumes one bus master, single word transfers, and asynchronous timer input pins.
 */
// Register access over AHB-Lite and the register addresses are this design's own decisions.
// What this block does
// - Each of the three timers can toggle its own output pin to make a square wave of equal high and low time.
// - The output changes on each overflow when counting up and on each underflow when counting down.
// - Counting down, the timer loads all ones after an underflow.
// - Counting down, an underflow is the count matching the 16-bit reload value.
// - Counting up, an overflow is the count leaving all ones, after which the reload value is loaded.
// - The wave frequency is the tick rate divided by twice the gap between 65536 and the reload value.
// - The output pin is driven only while the output-enable bit of the configuration register is one.
// - Toggling starts once the run bit is one while the capture-reload and external-count control bits are both zero.
// - Configuration bit 2 reads the toggle level, and writing it forces the output to that level.
`timescale 1ns/1ps
module tts_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    input wire logic [2:0] timerExtIn,
    output logic squareOutPinA,
    output logic squareOutPinAOeN,
    output logic squareOutPinB,
    output logic squareOutPinBOeN,
    output logic squareOutPinC,
    output logic squareOutPinCOeN
);
    import tts_pkg::*;

    function automatic logic tts_hit(
        input logic [31:0] addr,
        input int unsigned timerIdx,
        input logic [4:0] off
    );
        logic match;
        match = (addr[31:TTS_MAP_TOP] == '0);
        match = match && (addr[TTS_SEL_LSB +: TTS_SEL_W] == TTS_SEL_W'(timerIdx));
        match = match && (addr[TTS_OFF_W-1:0] == off);
        return match;
    endfunction : tts_hit

    tts_bus_st_t busSt_q;
    logic [31:0] addr_q;
    logic wrPend_q;
    logic [31:0] rdata_q;
    logic addrPhase;
    logic [31:0] rdWord [TTS_NUM_TIMERS];
    logic [TTS_NUM_TIMERS-1:0] pinLevel;
    logic [TTS_NUM_TIMERS-1:0] pinOeN;
    logic [31:0] rdMux;

    // Bus slave.
    assign addrPhase = hsel & htrans[TTS_HTRANS_ACTIVE] & hready;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_q <= TTS_WORD_ZERO;
        end else if (addrPhase) begin
            addr_q <= haddr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
        end else begin
            wrPend_q <= addrPhase & hwrite;
        end
    end

    // Reads take one wait state so a write just ahead is seen, except a forced toggle level, which lands one cycle later.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busSt_q <= TTS_BUS_IDLE;
        end else begin
            unique case (busSt_q)
                TTS_BUS_IDLE: begin
                    if (addrPhase && !hwrite) begin
                        busSt_q <= TTS_BUS_RDWAIT;
                    end
                end
                TTS_BUS_RDWAIT: begin
                    busSt_q <= TTS_BUS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rdMux = TTS_WORD_ZERO;
        for (int i = 0; i < TTS_NUM_TIMERS; i++) begin
            rdMux = rdMux | rdWord[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= TTS_WORD_ZERO;
        end else if (busSt_q == TTS_BUS_RDWAIT) begin
            rdata_q <= rdMux;
        end
    end

    assign hreadyout = (busSt_q != TTS_BUS_RDWAIT);
    assign hresp = TTS_HRESP_OKAY;
    assign hrdata = rdata_q;

    // Per-timer registers, tick source and counter.
    for (genvar g = 0; g < TTS_NUM_TIMERS; g++) begin : g_tmr
        tts_timer_if tif ();
        logic [2:0] ctrl_q;
        logic cfgDown_q;
        logic cfgOe_q;
        tts_cks_t cks_q;
        logic [7:0] rldLo_q;
        logic [7:0] rldHi_q;
        logic forceWr_q;
        logic forceVal_q;
        logic wrCtrl;
        logic wrCfg;
        logic wrLo;
        logic wrHi;

        assign wrCtrl = wrPend_q & tts_hit(addr_q, g, TTS_OFF_CTRL);
        assign wrCfg = wrPend_q & tts_hit(addr_q, g, TTS_OFF_CFG);
        assign wrLo = wrPend_q & tts_hit(addr_q, g, TTS_OFF_RLD_LO);
        assign wrHi = wrPend_q & tts_hit(addr_q, g, TTS_OFF_RLD_HI);

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                ctrl_q <= TTS_CTRL_RESET;
            end else if (wrCtrl) begin
                ctrl_q <= hwdata[TTS_CTRL_W-1:0];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cfgDown_q <= 1'b0;
                cfgOe_q <= 1'b0;
                cks_q <= TTS_CKS_REF;
            end else if (wrCfg) begin
                cfgDown_q <= hwdata[TTS_CFG_DOWN];
                cfgOe_q <= hwdata[TTS_CFG_OE];
                cks_q <= tts_cks_t'(hwdata[TTS_CFG_CKS_MSB:TTS_CFG_CKS_LSB]);
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                forceWr_q <= 1'b0;
                forceVal_q <= 1'b0;
            end else begin
                forceWr_q <= wrCfg;
                forceVal_q <= hwdata[TTS_CFG_TOG];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                rldLo_q <= TTS_BYTE_RESET;
            end else if (wrLo) begin
                rldLo_q <= hwdata[TTS_BYTE_W-1:0];
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                rldHi_q <= TTS_BYTE_RESET;
            end else if (wrHi) begin
                rldHi_q <= hwdata[TTS_BYTE_W-1:0];
            end
        end

        assign tif.run = ctrl_q[TTS_CTRL_RUN];
        assign tif.capRel = ctrl_q[TTS_CTRL_CAPREL];
        assign tif.extCnt = ctrl_q[TTS_CTRL_EXTCNT];
        assign tif.down = cfgDown_q;
        assign tif.outEn = cfgOe_q;
        assign tif.forceWr = forceWr_q;
        assign tif.forceVal = forceVal_q;
        assign tif.reloadValue = {rldHi_q, rldLo_q};

        tts_tick_gen u_tick (
            .ref_clk(ref_clk),
            .rst(rst),
            .extPin(timerExtIn[g]),
            .cks(cks_q),
            .extCnt(ctrl_q[TTS_CTRL_EXTCNT]),
            .tick(tif.tick)
        );

        tts_timer u_timer (
            .ref_clk(ref_clk),
            .rst(rst),
            .tif(tif)
        );

        always_comb begin
            rdWord[g] = TTS_WORD_ZERO;
            if (tts_hit(addr_q, g, TTS_OFF_CTRL)) begin
                rdWord[g][TTS_CTRL_W-1:0] = ctrl_q;
            end
            if (tts_hit(addr_q, g, TTS_OFF_CFG)) begin
                rdWord[g][TTS_CFG_DOWN] = cfgDown_q;
                rdWord[g][TTS_CFG_OE] = cfgOe_q;
                rdWord[g][TTS_CFG_TOG] = tif.toggleState;
                rdWord[g][TTS_CFG_CKS_MSB:TTS_CFG_CKS_LSB] = cks_q;
            end
            if (tts_hit(addr_q, g, TTS_OFF_RLD_LO)) begin
                rdWord[g][TTS_BYTE_W-1:0] = rldLo_q;
            end
            if (tts_hit(addr_q, g, TTS_OFF_RLD_HI)) begin
                rdWord[g][TTS_BYTE_W-1:0] = rldHi_q;
            end
            if (tts_hit(addr_q, g, TTS_OFF_COUNT)) begin
                rdWord[g][TTS_CNT_W-1:0] = tif.count;
            end
        end

        assign pinLevel[g] = tif.toggleState;
        assign pinOeN[g] = ~cfgOe_q;
    end

    assign squareOutPinA = pinLevel[0];
    assign squareOutPinAOeN = pinOeN[0];
    assign squareOutPinB = pinLevel[1];
    assign squareOutPinBOeN = pinOeN[1];
    assign squareOutPinC = pinLevel[2];
    assign squareOutPinCOeN = pinOeN[2];
endmodule : tts_top
